// ---- design/jtag_debug_port.sv ----
// jtag tap controller with bypass, idcode and debug-event pins
// Function
// - test logic advances and shifts only on edges of the external test clock
// - mode select sampled on test clock rise steers the tap state machine
// - serial test data input captured on test clock rise in shift-ir or shift-dr
// - test data output driven only in shift-ir or shift-dr, else released
// - test data output changes on the test clock falling edge
// - test reset low forces the tap controller into test-logic-reset
// - device reset alone leaves tap and debug state untouched
// - debug event output pulses low on each recognized event, else high
`timescale 1ns/1ps
`include "jtag_port_defines.svh"
module jtag_debug_port #(
    parameter int DEBUG_PULSE_CYCLES = `DEBUG_PULSE_CYCLES
) (
    // system
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // test pins
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    input  wire logic                 trst_n,
    output logic                      tdo_out,
    output logic                      tdo_oe_n,
    // debug
    input  wire logic                 core_debug_event,
    output logic                      debug_event_out_n,
    output jtag_port_pkg::tap_state_e tap_state
);
    import jtag_port_pkg::*;

    // two-flop synchronisers; the first stage feeds only the second
    // tck, tms, tdi and trst_n share one chain so their samples stay aligned
    logic [3:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic       tck_d_reg, tck_d_next;
    logic       tck_rise, tck_fall, tms_s, tdi_s, trst_s_n;

    // bypass uses only bit 0 of the data chain
    tap_state_e                state_reg, state_next;
    logic [`IR_WIDTH-1:0]      ir_reg, ir_next, ir_sh_reg, ir_sh_next;
    logic [31:0]               dr_sh_reg, dr_sh_next;
    logic                      tdo_reg, tdo_next, oe_n_reg, oe_n_next;
    logic [7:0]                pulse_cnt_reg, pulse_cnt_next;
    logic                      de_n_reg, de_n_next;
    logic                      ev_d_reg, ev_d_next;

    // pin edges are acted on three clk late; a test clock period of eight clk
    // keeps tms and tdi settled when the rise is used
    assign tms_s    = sync2_reg[1];
    assign tdi_s    = sync2_reg[2];
    assign trst_s_n = sync2_reg[3];
    assign tck_rise = sync2_reg[0] & ~tck_d_reg;
    assign tck_fall = ~sync2_reg[0] & tck_d_reg;

    always_comb begin
        sync1_next = {trst_n, tdi, tms, tck};
        sync2_next = sync1_reg;
        tck_d_next = sync2_reg[0];
    end

    // tap state machine
    // a low synchronised trst_n wins over any test clock edge in that cycle
    always_comb begin
        state_next = state_reg;
        if (!trst_s_n) begin
            state_next = TAP_RESET;
        end else if (tck_rise) begin
            case (state_reg)
                TAP_RESET:      state_next = tms_s ? TAP_RESET : TAP_IDLE;
                TAP_IDLE:       state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR:     state_next = tms_s ? TAP_SEL_IR : TAP_CAPTURE_DR;
                TAP_CAPTURE_DR: state_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR:   state_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR:   state_next = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
                TAP_PAUSE_DR:   state_next = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR:   state_next = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
                TAP_UPDATE_DR:  state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR:     state_next = tms_s ? TAP_RESET : TAP_CAPTURE_IR;
                TAP_CAPTURE_IR: state_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR:   state_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR:   state_next = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
                TAP_PAUSE_IR:   state_next = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR:   state_next = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
                TAP_UPDATE_IR:  state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
                default:        state_next = TAP_RESET;
            endcase
        end
    end

    // instruction and data shift paths
    always_comb begin
        ir_next    = ir_reg;
        ir_sh_next = ir_sh_reg;
        dr_sh_next = dr_sh_reg;
        if (!trst_s_n || state_reg == TAP_RESET) begin
            ir_next = `IR_RESET_VALUE;
        end else if (tck_rise) begin
            case (state_reg)
                TAP_CAPTURE_IR: ir_sh_next = `IR_CAPTURE_VALUE;
                TAP_SHIFT_IR:   ir_sh_next = {tdi_s, ir_sh_reg[`IR_WIDTH-1:1]};
                TAP_UPDATE_IR:  ir_next = ir_sh_reg;
                TAP_CAPTURE_DR: begin
                    // only idcode captures a value; bypass and debug capture zero
                    dr_sh_next = (ir_reg == `IR_IDCODE) ? `IDCODE_VALUE : 32'h0000_0000;
                end
                TAP_SHIFT_DR: begin
                    // idcode uses the full chain; bypass and debug are a single stage
                    if (ir_reg == `IR_IDCODE) begin
                        dr_sh_next = {tdi_s, dr_sh_reg[31:1]};
                    end else begin
                        dr_sh_next = {31'h0000_0000, tdi_s};
                    end
                end
                default: ir_sh_next = ir_sh_reg;
            endcase
        end
    end

    // output stage updated on the falling test clock edge
    // the enable follows the state seen at the fall, so it drops at the first
    // fall after shift is left, when the controller is not sampling
    always_comb begin
        tdo_next  = tdo_reg;
        oe_n_next = oe_n_reg;
        if (!trst_s_n) begin
            oe_n_next = 1'b1;
        end else if (tck_fall) begin
            oe_n_next = !(state_reg == TAP_SHIFT_IR || state_reg == TAP_SHIFT_DR);
            tdo_next  = (state_reg == TAP_SHIFT_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
        end
    end

    // debug event: core event or update-dr with the debug instruction
    // a new event during a running pulse restarts the count rather than
    // stretching into a second pulse that could not be told apart
    always_comb begin
        logic trig;
        trig           = (core_debug_event & ~ev_d_reg)
                       | (tck_rise && state_reg == TAP_UPDATE_DR && ir_reg == `IR_DEBUG_REQ);
        ev_d_next      = core_debug_event;
        pulse_cnt_next = pulse_cnt_reg;
        de_n_next      = 1'b1;
        if (trig) begin
            pulse_cnt_next = 8'(DEBUG_PULSE_CYCLES);
        end else if (pulse_cnt_reg != 8'h00) begin
            pulse_cnt_next = pulse_cnt_reg - 8'h01;
        end
        if (pulse_cnt_next != 8'h00) begin
            de_n_next = 1'b0;
        end
    end

    // rst_n is the test logic's power-on reset only; a device reset that
    // leaves trst_n high does not reach here, so debug state survives it
    // the test clock idles low, so a zeroed chain shows no false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            tck_d_reg <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            tck_d_reg <= tck_d_next;
        end
    end

    // tap state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= TAP_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // instruction and data chain registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_reg    <= `IR_RESET_VALUE;
            ir_sh_reg <= `IR_RESET_VALUE;
            dr_sh_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            ir_reg    <= ir_next;
            ir_sh_reg <= ir_sh_next;
            dr_sh_reg <= dr_sh_next;
        end
    end

    // output registers; tdo leaves reset released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_reg  <= 1'b0;
            oe_n_reg <= 1'b1;
        end else if (clk_en) begin
            tdo_reg  <= tdo_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // debug pulse registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_reg <= 8'h00;
            de_n_reg      <= 1'b1;
            ev_d_reg      <= 1'b0;
        end else if (clk_en) begin
            pulse_cnt_reg <= pulse_cnt_next;
            de_n_reg      <= de_n_next;
            ev_d_reg      <= ev_d_next;
        end
    end

    assign tdo_out           = tdo_reg;
    assign tdo_oe_n          = oe_n_reg;
    assign debug_event_out_n = de_n_reg;
    assign tap_state         = state_reg;
endmodule

// ---- design/jtag_port_defines.svh ----
// timing and encoding constants for the jtag test port
`ifndef JTAG_PORT_DEFINES_SVH
`define JTAG_PORT_DEFINES_SVH
`define IR_WIDTH            4
`define IR_RESET_VALUE      4'h1
`define IR_CAPTURE_VALUE    4'h1
`define IR_BYPASS           4'hF
`define IR_IDCODE           4'h2
`define IR_DEBUG_REQ        4'h7
// arbitrary identity value; it names no real maker or part
`define IDCODE_VALUE        32'h1234_5001
`define DEBUG_PULSE_NS      100
`define CLK_PERIOD_NS       50
`define DEBUG_PULSE_CYCLES  ((`DEBUG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- design/jtag_port_pkg.sv ----
// types for the jtag test port
package jtag_port_pkg;
    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } tap_state_e;
endpackage

// ---- verif/jtag_debug_port_properties.sv ----
// concurrent checks on the jtag port pins
`timescale 1ns/1ps
module jtag_debug_port_properties
    import jtag_port_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       tck,
    input wire logic       trst_n,
    input wire logic       tdo_out,
    input wire logic       tdo_oe_n,
    input wire logic       core_debug_event,
    input wire logic       debug_event_out_n,
    input wire tap_state_e tap_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_TRST_RESET: assert property ((!trst_n) [*4] |-> tap_state == TAP_RESET)
        else $error("tap not reset by test reset");
    AST_TDO_SHIFT_ONLY: assert property (!tdo_oe_n |-> tap_state inside
        {TAP_SHIFT_DR, TAP_SHIFT_IR, TAP_EXIT1_DR, TAP_EXIT1_IR}) else $error("tdo driven off shift");
    AST_TDO_OFF_RESET: assert property (tap_state == TAP_RESET |-> tdo_oe_n)
        else $error("tdo driven in reset state");
    AST_TDO_ON_FALL: assert property ($changed(tdo_out) || $changed(tdo_oe_n)
        |-> !tck && !$past(tck, 2)) else $error("tdo moved outside low test clock");
    AST_STATE_ON_RISE: assert property ($changed(tap_state) && tap_state != TAP_RESET
        |-> tck && $past(tck, 2)) else $error("tap moved without test clock rise");
    AST_IDLE_NEXT: assert property ($past(tap_state) == TAP_IDLE && $changed(tap_state)
        |-> tap_state == TAP_SEL_DR) else $error("bad exit from idle");
    AST_EVENT_PULSE: assert property ($rose(core_debug_event)
        |=> !debug_event_out_n [*2] ##1 debug_event_out_n) else $error("debug pulse wrong");
    AST_EVENT_IDLE_HIGH: assert property (!debug_event_out_n
        |-> $past(core_debug_event) || $past(core_debug_event, 2)
            || $past(tap_state) == TAP_UPDATE_DR || $past(tap_state, 2) == TAP_UPDATE_DR)
        else $error("spurious pulse");
endmodule
bind jtag_debug_port jtag_debug_port_properties u_props (.clk, .rst_n, .tck, .trst_n,
    .tdo_out, .tdo_oe_n, .core_debug_event, .debug_event_out_n, .tap_state);

// ---- verif/jtag_host.sv ----
// behavioural jtag controller driving the test pins
`timescale 1ns/1ps
module jtag_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input wire logic  tdo_out,
    input wire logic  tdo_oe_n
);
    // test clock stands low between cycles, as the pull-down leaves it
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
        #500 trst_n = 1'b1;
    end
    // tdo moves within three clk (150 ns) of the fall, so it is taken late in the high phase
    task automatic cyc(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        // a released tdo has no pull, so the model reads it as the inverse
        #190 q = tdo_oe_n ? ~tdo_out : tdo_out;
        #10 tck = 1'b0;
    endtask
endmodule

// ---- verif/test_jtag_debug_port.sv ----
// self-checking bench for the jtag debug port
`timescale 1ns/1ps
`include "jtag_port_defines.svh"
module test_jtag_debug_port;
    import jtag_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        core_debug_event = 1'b0;
    logic        clk_en = 1'b1;
    int          low_total = 0;
    logic        tck, tms, tdi, trst_n, tdo_out, tdo_oe_n, debug_event_out_n;
    tap_state_e  tap_state;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    integer      seed = 32'h820f_37aa;
    logic [31:0] got, pat;
    always #25 clk = ~clk;
    jtag_debug_port u_dut (.clk, .rst_n, .clk_en, .tck, .tms, .tdi, .trst_n, .tdo_out,
        .tdo_oe_n, .core_debug_event, .debug_event_out_n, .tap_state);
    jtag_host u_host (.tck, .tms, .tdi, .trst_n, .tdo_out, .tdo_oe_n);
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_st(input tap_state_e e);
        total_checks++;
        if (tap_state !== e) begin
            bad_count++;
            $display("ERROR tap_state exp %h got %h", e, tap_state);
        end
    endtask
    task automatic cmp_v(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    // bypass holds one zero stage, so the stream comes back one bit late
    function automatic logic [31:0] bypass_exp(input logic [31:0] d);
        return {d[30:0], 1'b0};
    endfunction
    task automatic walk(input logic [7:0] m, input int k);
        logic b;
        for (int i = 0; i < k; i++) u_host.cyc(m[i], 1'b0, b);
    endtask
    // last bit leaves the shift state, as the controller must
    task automatic shift(input logic [31:0] d, input int k, output logic [31:0] q);
        logic b;
        q = 32'h0000_0000;
        for (int i = 0; i < k; i++) begin
            u_host.cyc(i == k - 1, d[i], b);
            q[i] = b;
        end
    endtask
    task automatic load_ir(input logic [3:0] v);
        walk(8'h03, 4);
        cmp_st(TAP_SHIFT_IR);
        shift({28'h0, v}, 4, got);
        cmp_v("ir capture", `IR_CAPTURE_VALUE, got[3:0]);
        walk(8'h01, 2);
        walk(8'h01, 3);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #5 rst_n = 1'b1;
        cmp_st(TAP_RESET);
        cmp_v("tdo_oe_n", 1, tdo_oe_n);
        #1000 walk(8'h00, 1);
        cmp_st(TAP_IDLE);
        load_ir(`IR_IDCODE);
        shift(32'h0, 32, got);
        cmp_v("idcode", `IDCODE_VALUE, got);
        walk(8'h01, 2);
        load_ir(`IR_BYPASS);
        pat = $random(seed);
        shift(pat, 32, got);
        cmp_v("bypass", bypass_exp(pat), got);
        walk(8'h01, 2);
        cmp_st(TAP_IDLE);
        cmp_v("idle pulses", 0, low_total);
        load_ir(`IR_DEBUG_REQ);
        shift(pat, 1, got);
        cmp_v("debug chain", 0, got);
        walk(8'h01, 2);
        #400 cmp_v("request pulse", `DEBUG_PULSE_CYCLES, low_total);
        clk_en = 1'b0;
        walk(8'h01, 1);
        #200 clk_en = 1'b1;
        #400 cmp_st(TAP_IDLE);
        repeat (3) begin
            repeat ($unsigned($random(seed)) % 4 + 2) @(posedge clk);
            #5 core_debug_event = 1'b1;
            n = 0;
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                #5 core_debug_event = 1'b0;
                if (debug_event_out_n === 1'b0) n++;
            end
            cmp_v("pulse len", `DEBUG_PULSE_CYCLES, n);
        end
        walk(8'h01, 3);
        #200 cmp_v("tdo_oe_n", 0, tdo_oe_n);
        u_host.trst_n = 1'b0;
        #400 cmp_st(TAP_RESET);
        cmp_v("tdo_oe_n", 1, tdo_oe_n);
        u_host.trst_n = 1'b1;
        close_out();
    end
    always @(negedge clk) begin
        if (debug_event_out_n === 1'b0) begin
            low_total++;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 6000) begin
            bad_count++;
            close_out();
        end
    end
endmodule
